// >>> verilog/mdw_sequencer.sv
`timescale 1ns/1ps
module mdw_sequencer #(
    parameter int unsigned MAX_INTERVAL_CYC = mdw_pkg::MAX_INTERVAL_CYC,
    parameter logic [7:0]  ID_CODE          = 8'hA5, // Arbitrary value
    parameter bit          ZERO_WAIT_WRITES = 1'b0
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // Register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic [1:0]  be_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic        id_sel_i,
    input  wire logic        intsel_i,
    output logic      [15:0] rdata_o,
    output logic             ack_o,
    // External trigger
    input  wire logic        ext_trig_n_i,
    // Converter outputs
    output logic [7:0][15:0] dac_data_o,
    output logic             dac_load_o,
    // Interrupt
    output logic             irq_o
);

    // Register state
    logic [15:0]                 ctrl_reg;
    logic [15:0]                 ctrl_next;
    logic [15:0]                 pre_reg;
    logic [15:0]                 pre_next;
    logic [15:0]                 tmr_reg;
    logic [15:0]                 tmr_next;
    logic [15:0]                 wma_reg;
    logic [15:0]                 wma_next;
    logic [15:0]                 ivec_reg;
    logic [15:0]                 ivec_next;
    logic                        stat_reg;
    logic                        stat_next;
    logic                        mask_reg;
    logic                        mask_next;
    // Sequencer state
    mdw_pkg::mdw_state_type      state_reg;
    mdw_pkg::mdw_state_type      state_next;
    logic [10:0]                 ptr_reg;
    logic [10:0]                 ptr_next;
    logic                        fetch_reg;
    logic                        ext_prev_reg;
    logic [7:0][15:0]            dac_reg;
    logic                        load_reg;
    logic                        irq_reg;
    // Bus answer state
    logic                        ack_reg;
    logic                        ack_next;
    logic [2:0]                  wcnt_reg;
    logic [2:0]                  wcnt_next;
    logic [15:0]                 rdata_reg;

    // Decode
    logic                        io_wr_w;
    logic                        io_rd_w;
    logic                        hit_ctrl_w;
    logic                        hit_pre_w;
    logic                        hit_tmr_w;
    logic                        hit_wmd_w;
    logic                        hit_wma_w;
    logic                        hit_start_w;
    logic                        hit_stat_w;
    logic                        hit_mask_w;
    logic                        hit_ivec_w;
    logic                        hit_sptr_w;
    logic                        mem_acc_w;
    logic                        strobe_w;
    logic [2:0]                  wait_w;
    logic [15:0]                 rd_io_w;
    logic [15:0]                 rd_id_w;
    logic [15:0]                 rd_val_w;
    logic [15:0]                 host_q_w;
    logic [7:0][15:0]            seq_q_w;

    // Sequencing
    mdw_pkg::mdw_mode_type       mode_w;
    logic                        sw_trig_w;
    logic                        halt_w;
    logic                        ext_fall_w;
    logic                        trig_w;
    logic                        start_w;
    logic                        step_w;
    logic                        run_fetch_w;
    logic                        fetch_w;
    logic                        last_w;
    logic                        tick_w;
    logic [10:0]                 seq_ptr_w;
    logic                        done_evt_w;
    logic                        stat_clr_w;

    assign io_wr_w = wr_i & ~id_sel_i;
    assign io_rd_w = rd_i & ~id_sel_i;

    assign hit_ctrl_w  = (addr_i == mdw_pkg::OFF_CTRL);
    assign hit_pre_w   = (addr_i == mdw_pkg::OFF_PRESCALE);
    assign hit_tmr_w   = (addr_i == mdw_pkg::OFF_TIMER);
    assign hit_wmd_w   = (addr_i == mdw_pkg::OFF_WMDATA);
    assign hit_wma_w   = (addr_i == mdw_pkg::OFF_WMADDR);
    assign hit_start_w = (addr_i == mdw_pkg::OFF_START);
    assign hit_stat_w  = (addr_i == mdw_pkg::OFF_STATUS);
    assign hit_mask_w  = (addr_i == mdw_pkg::OFF_MASK);
    assign hit_ivec_w  = (addr_i == mdw_pkg::OFF_IVEC);
    assign hit_sptr_w  = (addr_i == mdw_pkg::OFF_SEQPTR);

    // Unmapped I/O offsets read as zero and ignore writes
    assign rd_io_w =
        hit_ctrl_w ? ctrl_reg :
        hit_pre_w  ? pre_reg  :
        hit_tmr_w  ? tmr_reg  :
        hit_wmd_w  ? host_q_w :
        hit_wma_w  ? wma_reg  :
        hit_stat_w ? {14'h0000, state_reg == mdw_pkg::ST_RUN, stat_reg} :
        hit_mask_w ? {15'h0000, mask_reg} :
        hit_ivec_w ? ivec_reg :
        hit_sptr_w ? {5'h00, ptr_reg} : mdw_pkg::ZERO16;
    assign rd_id_w = (addr_i == mdw_pkg::ID_OFF_SIG) ?
                     {8'h00, ID_CODE} : mdw_pkg::ZERO16;
    assign rd_val_w = intsel_i ? {8'h00, ivec_reg[7:0]} :
                      id_sel_i ? rd_id_w : rd_io_w;

    // Wait-state class of the access in this cycle
    assign mem_acc_w = ~id_sel_i & hit_wmd_w;
    assign strobe_w  = wr_i | rd_i | intsel_i;
    assign wait_w =
        intsel_i  ? mdw_pkg::WAIT_IVEC :
        mem_acc_w ? mdw_pkg::WAIT_MEM :
        wr_i      ? (ZERO_WAIT_WRITES ? mdw_pkg::WAIT_WR_FAST
                                      : mdw_pkg::WAIT_WR) :
        mdw_pkg::WAIT_REG_RD;
    // A new strobe restarts the count; masters wait for ack first
    assign ack_next  = strobe_w ? (wait_w == 3'h0) : (wcnt_reg == 3'h1);
    assign wcnt_next = strobe_w ? wait_w :
                       (wcnt_reg != 3'h0) ? wcnt_reg - 3'h1 : 3'h0;

    // Register writes with byte lanes
    assign ctrl_next = (io_wr_w & hit_ctrl_w) ?
        mdw_pkg::merge16(ctrl_reg, wdata_i, be_i) : ctrl_reg;
    assign pre_next  = (io_wr_w & hit_pre_w) ?
        mdw_pkg::merge16(pre_reg, wdata_i, be_i) : pre_reg;
    assign tmr_next  = (io_wr_w & hit_tmr_w) ?
        mdw_pkg::merge16(tmr_reg, wdata_i, be_i) : tmr_reg;
    assign ivec_next = (io_wr_w & hit_ivec_w) ?
        mdw_pkg::merge16(ivec_reg, wdata_i, be_i) : ivec_reg;
    assign mask_next = (io_wr_w & hit_mask_w & be_i[0]) ?
        wdata_i[mdw_pkg::STAT_DONE_BIT] : mask_reg;
    // Memory pointer steps after each data access for block loads
    assign wma_next =
        (io_wr_w & hit_wma_w) ? mdw_pkg::merge16(wma_reg, wdata_i, be_i) :
        ((io_wr_w | io_rd_w) & hit_wmd_w) ?
            {wma_reg[15:11], wma_reg[10:0] + 11'h001} : wma_reg;

    // Triggers
    assign mode_w = mdw_pkg::mdw_mode_type'(
        ctrl_reg[mdw_pkg::CTRL_MODE_HI:mdw_pkg::CTRL_MODE_LO]);
    assign sw_trig_w  = io_wr_w & hit_start_w & be_i[0] &
                        wdata_i[mdw_pkg::START_SW_BIT];
    assign halt_w     = io_wr_w & hit_start_w & be_i[0] &
                        wdata_i[mdw_pkg::START_HALT_BIT];
    assign ext_fall_w = ctrl_reg[mdw_pkg::CTRL_EXT_BIT] &
                        ext_prev_reg & ~ext_trig_n_i;
    assign trig_w = sw_trig_w | ext_fall_w;

    // Triggers while running are ignored
    assign start_w = (state_reg == mdw_pkg::ST_IDLE) & trig_w &
                     ~halt_w & ((mode_w == mdw_pkg::MODE_ONCE) |
                                (mode_w == mdw_pkg::MODE_CONT));
    assign step_w  = (state_reg == mdw_pkg::ST_IDLE) & trig_w &
                     (mode_w == mdw_pkg::MODE_STEP);
    assign run_fetch_w = (state_reg == mdw_pkg::ST_RUN) & tick_w &
                         ~halt_w;
    assign fetch_w   = start_w | step_w | run_fetch_w;
    assign seq_ptr_w = start_w ? mdw_pkg::PTR_FIRST : ptr_reg;
    assign last_w    = fetch_w & (seq_ptr_w == mdw_pkg::PTR_LAST);
    // 11-bit pointer wraps to the first location by itself
    assign ptr_next  = fetch_w ? seq_ptr_w + 11'h001 : ptr_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            mdw_pkg::ST_IDLE: begin
                if (start_w) begin
                    state_next = mdw_pkg::ST_RUN;
                end
            end
            mdw_pkg::ST_RUN: begin
                if (halt_w) begin
                    state_next = mdw_pkg::ST_IDLE;
                end else if (last_w &&
                             mode_w != mdw_pkg::MODE_CONT) begin
                    state_next = mdw_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = mdw_pkg::ST_IDLE;
            end
        endcase
    end

    // Completed pass; a clear in the same cycle loses to the event
    assign done_evt_w = last_w & ctrl_reg[mdw_pkg::CTRL_IRQ_BIT];
    assign stat_clr_w = io_wr_w & hit_stat_w & be_i[0] &
                        wdata_i[mdw_pkg::STAT_DONE_BIT];
    assign stat_next  = done_evt_w | (stat_reg & ~stat_clr_w);

    mdw_interval_timer #(
        .MAX_CYC    (MAX_INTERVAL_CYC)
    ) u_timer (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .restart_i  (start_w),
        .run_i      (state_reg == mdw_pkg::ST_RUN),
        .prescale_i (pre_reg),
        .count_i    (tmr_reg),
        .tick_o     (tick_w)
    );

    mdw_wave_mem u_mem (
        .clk_i        (clk_i),
        .host_we_i    (io_wr_w & hit_wmd_w),
        .host_be_i    (be_i),
        .host_ch_i    (wma_reg[mdw_pkg::WMA_CH_HI:mdw_pkg::WMA_CH_LO]),
        .host_ptr_i   (wma_reg[mdw_pkg::WMA_PTR_HI:0]),
        .host_wdata_i (wdata_i),
        .host_q_o     (host_q_w),
        .seq_ptr_i    (seq_ptr_w),
        .seq_q_o      (seq_q_w)
    );

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_reg <= mdw_pkg::CTRL_RST;
            pre_reg  <= mdw_pkg::PRESCALE_RST;
            tmr_reg  <= mdw_pkg::TIMER_RST;
            wma_reg  <= mdw_pkg::WMADDR_RST;
            ivec_reg <= mdw_pkg::IVEC_RST;
            mask_reg <= 1'b0;
            stat_reg <= 1'b0;
            irq_reg  <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            pre_reg  <= pre_next;
            tmr_reg  <= tmr_next;
            wma_reg  <= wma_next;
            ivec_reg <= ivec_next;
            mask_reg <= mask_next;
            stat_reg <= stat_next;
            irq_reg  <= stat_reg & mask_reg;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg    <= mdw_pkg::ST_IDLE;
            ptr_reg      <= mdw_pkg::PTR_FIRST;
            fetch_reg    <= 1'b0;
            ext_prev_reg <= 1'b1;
            load_reg     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            ptr_reg      <= ptr_next;
            fetch_reg    <= fetch_w;
            ext_prev_reg <= ext_trig_n_i;
            load_reg     <= fetch_reg;
        end
    end

    // Codes pass unchanged; reset value is midscale
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dac_reg <= {mdw_pkg::CHANNELS{mdw_pkg::DAC_MIDSCALE}};
        end else if (fetch_reg) begin
            dac_reg <= seq_q_w;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_reg   <= 1'b0;
            wcnt_reg  <= 3'h0;
            rdata_reg <= mdw_pkg::ZERO16;
        end else begin
            ack_reg  <= ack_next;
            wcnt_reg <= wcnt_next;
            if (rd_i || intsel_i) begin
                rdata_reg <= rd_val_w;
            end
        end
    end

    assign rdata_o    = rdata_reg;
    assign ack_o      = ack_reg;
    assign dac_data_o = dac_reg;
    assign dac_load_o = load_reg;
    assign irq_o      = irq_reg;

endmodule : mdw_sequencer

// >>> include/mdw_pkg.sv
package mdw_pkg;

    // Geometry
    localparam int CHANNELS = 8;
    localparam int DATA_W   = 16;
    localparam int DEPTH    = 2048;
    localparam int PTR_W    = 11;
    localparam int CH_W     = 3;
    localparam int ADDR_W   = 8;

    localparam logic [PTR_W-1:0] PTR_FIRST = 11'h000;
    localparam logic [PTR_W-1:0] PTR_LAST  = 11'h7FF;

    // I/O space offsets, byte addresses of 16-bit registers
    localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PRESCALE = 8'h02;
    localparam logic [ADDR_W-1:0] OFF_TIMER    = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_WMDATA   = 8'h06;
    localparam logic [ADDR_W-1:0] OFF_WMADDR   = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_START    = 8'h0A;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_MASK     = 8'h0E;
    localparam logic [ADDR_W-1:0] OFF_IVEC     = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_SEQPTR   = 8'h12;
    // ID space offset
    localparam logic [ADDR_W-1:0] ID_OFF_SIG   = 8'h00;

    // Field positions
    localparam int CTRL_MODE_LO   = 0;
    localparam int CTRL_MODE_HI   = 1;
    localparam int CTRL_EXT_BIT   = 2;
    localparam int CTRL_IRQ_BIT   = 3;
    localparam int START_SW_BIT   = 0;
    localparam int START_HALT_BIT = 1;
    localparam int STAT_DONE_BIT  = 0;
    localparam int STAT_RUN_BIT   = 1;
    localparam int WMA_PTR_HI     = 10;
    localparam int WMA_CH_LO      = 12;
    localparam int WMA_CH_HI      = 14;

    // Reset values
    localparam logic [DATA_W-1:0] CTRL_RST     = 16'h0000;
    localparam logic [DATA_W-1:0] PRESCALE_RST = 16'h0000;
    localparam logic [DATA_W-1:0] TIMER_RST    = 16'h0000;
    localparam logic [DATA_W-1:0] WMADDR_RST   = 16'h0000;
    localparam logic [DATA_W-1:0] IVEC_RST     = 16'h0000;
    localparam logic [DATA_W-1:0] DAC_MIDSCALE = 16'h0000;
    localparam logic [DATA_W-1:0] ZERO16       = 16'h0000;

    // Wait states per access class
    localparam logic [2:0] WAIT_REG_RD  = 3'h1;
    localparam logic [2:0] WAIT_IVEC    = 3'h1;
    localparam logic [2:0] WAIT_WR      = 3'h1;
    localparam logic [2:0] WAIT_WR_FAST = 3'h0;
    localparam logic [2:0] WAIT_MEM     = 3'h4;

    // Interval limits
    localparam longint CLK_PERIOD_NS    = 25;
    localparam longint MIN_INTERVAL_NS  = 6700;
    localparam longint MAX_INTERVAL_NS  = 64'd2090000000;
    localparam int MIN_INTERVAL_CYC =
        int'((MIN_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int MAX_INTERVAL_CYC =
        int'(MAX_INTERVAL_NS / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        MODE_STEP,
        MODE_ONCE,
        MODE_CONT,
        MODE_NONE
    } mdw_mode_type;

    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } mdw_state_type;

    // Byte-lane merge for 8-bit and 16-bit writes
    function automatic logic [DATA_W-1:0] merge16(
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v,
        input logic [1:0]        be
    );
        merge16 = {be[1] ? new_v[15:8] : old_v[15:8],
                   be[0] ? new_v[7:0]  : old_v[7:0]};
    endfunction : merge16

endpackage : mdw_pkg

// >>> verilog/mdw_interval_timer.sv
`timescale 1ns/1ps
module mdw_interval_timer #(
    parameter int unsigned MAX_CYC = mdw_pkg::MAX_INTERVAL_CYC
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // Control
    input  wire logic        restart_i,
    input  wire logic        run_i,
    input  wire logic [15:0] prescale_i,
    input  wire logic [15:0] count_i,
    // Expiry
    output logic             tick_o
);

    localparam logic [33:0] MIN34 = 34'(mdw_pkg::MIN_INTERVAL_CYC);
    localparam logic [33:0] MAX34 = 34'(MAX_CYC);

    logic [33:0] raw_w;
    logic [31:0] interval_w;
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;

    // Clamped so software cannot leave the supported range
    assign raw_w = ({18'h00000, prescale_i} + 34'h1)
                 * ({18'h00000, count_i} + 34'h1);
    assign interval_w = (raw_w < MIN34) ? MIN34[31:0] :
                        (raw_w > MAX34) ? MAX34[31:0] : raw_w[31:0];
    assign tick_o   = run_i & (cnt_reg == 32'h0);
    assign cnt_next = restart_i ? interval_w - 32'h1 :
                      tick_o    ? interval_w - 32'h1 :
                      run_i     ? cnt_reg - 32'h1 : cnt_reg;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_reg <= 32'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

endmodule : mdw_interval_timer

// >>> verilog/mdw_wave_mem.sv
`timescale 1ns/1ps
module mdw_wave_mem (
    // Clock
    input  wire logic        clk_i,
    // Host port
    input  wire logic        host_we_i,
    input  wire logic [1:0]  host_be_i,
    input  wire logic [2:0]  host_ch_i,
    input  wire logic [10:0] host_ptr_i,
    input  wire logic [15:0] host_wdata_i,
    output logic      [15:0] host_q_o,
    // Sequencer port, all channels at once
    input  wire logic [10:0] seq_ptr_i,
    output logic [7:0][15:0] seq_q_o
);

    logic [15:0] mem_arr [mdw_pkg::CHANNELS][mdw_pkg::DEPTH];

    always_ff @(posedge clk_i) begin
        if (host_we_i && host_be_i[0]) begin
            mem_arr[host_ch_i][host_ptr_i][7:0] <= host_wdata_i[7:0];
        end
        if (host_we_i && host_be_i[1]) begin
            mem_arr[host_ch_i][host_ptr_i][15:8] <= host_wdata_i[15:8];
        end
        host_q_o <= mem_arr[host_ch_i][host_ptr_i];
        for (int c = 0; c < mdw_pkg::CHANNELS; c++) begin
            seq_q_o[c] <= mem_arr[c][seq_ptr_i];
        end
    end

endmodule : mdw_wave_mem

// >>> tb/mdw_sequencer_assertions.sv
`timescale 1ns/1ps
module mdw_sequencer_checker #(
    parameter logic [7:0] ID_CODE          = 8'hA5, // Arbitrary value
    parameter bit         ZERO_WAIT_WRITES = 1'b0
) (
    // Watched ports
    input wire logic             clk_i,
    input wire logic             resetn_i,
    input wire logic [7:0]       addr_i,
    input wire logic [15:0]      wdata_i,
    input wire logic [1:0]       be_i,
    input wire logic             wr_i,
    input wire logic             rd_i,
    input wire logic             id_sel_i,
    input wire logic             intsel_i,
    input wire logic [15:0]      rdata_o,
    input wire logic             ack_o,
    input wire logic             ext_trig_n_i,
    input wire logic [7:0][15:0] dac_data_o,
    input wire logic             dac_load_o,
    input wire logic             irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    wire logic mem_acc;
    wire logic stat_clr;
    assign mem_acc  = !id_sel_i && addr_i == mdw_pkg::OFF_WMDATA;
    assign stat_clr = wr_i && !id_sel_i && be_i[0] && wdata_i[0]
                      && addr_i == mdw_pkg::OFF_STATUS;
    sequence s_one_wait;
        !ack_o ##1 ack_o ##1 !ack_o;
    endsequence
    sequence s_mem_wait;
        !ack_o [*4] ##1 ack_o;
    endsequence
    a_reg_read_wait: assert property (
        rd_i && !mem_acc |=> s_one_wait)
        else $error("register read ack timing wrong");
    a_ivec_wait: assert property (
        intsel_i |=> s_one_wait)
        else $error("vector cycle ack timing wrong");
    a_write_wait: assert property (
        wr_i && !mem_acc && !ZERO_WAIT_WRITES |=> s_one_wait)
        else $error("write ack timing wrong");
    a_write_fast: assert property (
        wr_i && !mem_acc && ZERO_WAIT_WRITES |=> ack_o)
        else $error("fast write ack timing wrong");
    a_mem_wait: assert property (
        (rd_i || wr_i) && mem_acc |=> s_mem_wait)
        else $error("memory access ack timing wrong");
    a_id_value: assert property (
        rd_i && id_sel_i && addr_i == mdw_pkg::ID_OFF_SIG
        |=> rdata_o == {8'h00, ID_CODE})
        else $error("signature read wrong");
    a_rdata_hold: assert property (
        !rd_i && !intsel_i |=> $stable(rdata_o))
        else $error("read data moved without a read");
    a_dac_hold: assert property (
        !dac_load_o |-> $stable(dac_data_o))
        else $error("channel data moved without load");
    a_irq_cause: assert property (
        $rose(irq_o) |-> dac_load_o || $past(wr_i, 2))
        else $error("interrupt rose without cause");
    a_irq_clear: assert property (
        stat_clr |=> ##1 !irq_o)
        else $error("interrupt stayed after clear");
endmodule : mdw_sequencer_checker

bind mdw_sequencer mdw_sequencer_checker #(
    .ID_CODE         (ID_CODE),
    .ZERO_WAIT_WRITES(ZERO_WAIT_WRITES)
) i_mdw_sequencer_checker (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .addr_i      (addr_i),
    .wdata_i     (wdata_i),
    .be_i        (be_i),
    .wr_i        (wr_i),
    .rd_i        (rd_i),
    .id_sel_i    (id_sel_i),
    .intsel_i    (intsel_i),
    .rdata_o     (rdata_o),
    .ack_o       (ack_o),
    .ext_trig_n_i(ext_trig_n_i),
    .dac_data_o  (dac_data_o),
    .dac_load_o  (dac_load_o),
    .irq_o       (irq_o)
);

// >>> tb/mdw_host_model.sv
`timescale 1ns/1ps
module mdw_host_model (
    // Clock
    input  wire logic        clk_i,
    // Requests
    output logic      [7:0]  addr_o,
    output logic      [15:0] wdata_o,
    output logic      [1:0]  be_o,
    output logic             wr_o,
    output logic             rd_o,
    output logic             id_sel_o,
    output logic             intsel_o,
    // Answers
    input  wire logic [15:0] rdata_i,
    input  wire logic        ack_i
);
    initial begin
        addr_o   = 8'h00;
        wdata_o  = 16'h0000;
        be_o     = 2'h0;
        wr_o     = 1'b0;
        rd_o     = 1'b0;
        id_sel_o = 1'b0;
        intsel_o = 1'b0;
    end
    // Kind 0 write, 1 read, 2 vector cycle
    task automatic xfer(input logic [1:0] k, input logic [7:0] a,
                        input logic [15:0] d, input logic [1:0] b,
                        input logic id, output logic [15:0] q);
        @(posedge clk_i);
        addr_o   <= a;
        wdata_o  <= d;
        be_o     <= b;
        id_sel_o <= id;
        wr_o     <= (k == 2'h0);
        rd_o     <= (k == 2'h1);
        intsel_o <= (k == 2'h2);
        @(posedge clk_i);
        // Released lines must not look like a held value
        addr_o   <= ~a;
        wdata_o  <= ~d;
        id_sel_o <= 1'b0;
        wr_o     <= 1'b0;
        rd_o     <= 1'b0;
        intsel_o <= 1'b0;
        #1;
        q = rdata_i;
        // Unbounded on purpose: a lost ack ends in the bench watchdog
        while (ack_i !== 1'b1) begin
            @(posedge clk_i);
            #1;
        end
    endtask : xfer
endmodule : mdw_host_model

// >>> tb/mdw_sequencer_tb.sv
`timescale 1ns/1ps
module mdw_sequencer_tb;
    localparam logic [7:0] ID_VAL = 8'h3C; // Arbitrary value
    logic             clk_i;
    logic             resetn_i;
    logic             ext_trig_n_i;
    logic [7:0]       addr;
    logic [15:0]      wdata;
    logic [15:0]      rdata;
    logic [1:0]       be;
    logic             wr;
    logic             rd;
    logic             id_sel;
    logic             intsel;
    logic             ack;
    logic             dac_load;
    logic             irq;
    logic [7:0][15:0] dac_data;
    int               err_total;
    int               cmp_count;

    mdw_host_model i_mdw_host_model (.clk_i(clk_i), .addr_o(addr),
        .wdata_o(wdata), .be_o(be), .wr_o(wr), .rd_o(rd),
        .id_sel_o(id_sel), .intsel_o(intsel), .rdata_i(rdata),
        .ack_i(ack));
    mdw_sequencer #(.MAX_INTERVAL_CYC(1000), .ID_CODE(ID_VAL))
    i_mdw_sequencer (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr),
        .wdata_i(wdata), .be_i(be), .wr_i(wr), .rd_i(rd),
        .id_sel_i(id_sel), .intsel_i(intsel), .rdata_o(rdata),
        .ack_o(ack), .ext_trig_n_i(ext_trig_n_i),
        .dac_data_o(dac_data), .dac_load_o(dac_load), .irq_o(irq));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    function automatic logic [15:0] val(input int c, input int l);
        case ((c + l) % 4)
            0: val = 16'h7FFF;
            1: val = 16'h0000;
            2: val = 16'hFFFF;
            default: val = 16'h8000;
        endcase
    endfunction : val
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        i_mdw_host_model.xfer(2'h0, a, d, 2'h3, 1'b0, q);
    endtask : wr16
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] q;
        i_mdw_host_model.xfer(2'h1, a, 16'h0000, 2'h3, 1'b0, q);
        check(q, e);
    endtask : rd_chk
    task automatic chk_dac(input int l);
        for (int c = 0; c < 8; c++) begin
            check(dac_data[c], val(c, l));
        end
    endtask : chk_dac
    // Bounded: 2000 means no load came
    task automatic wait_load(output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (dac_load !== 1'b1 && n < 2000);
    endtask : wait_load
    task automatic t_regs;
        logic [15:0] q;
        rd_chk(mdw_pkg::OFF_CTRL, mdw_pkg::CTRL_RST);
        rd_chk(8'h20, 16'h0000);
        wr16(mdw_pkg::OFF_IVEC, 16'h00C3);
        i_mdw_host_model.xfer(2'h0, mdw_pkg::OFF_TIMER, 16'hAB12, 2'h1,
                              1'b0, q);
        rd_chk(mdw_pkg::OFF_TIMER, 16'h0012);
        i_mdw_host_model.xfer(2'h2, 8'h00, 16'h0000, 2'h0, 1'b0, q);
        check(q, 16'h00C3);
        i_mdw_host_model.xfer(2'h1, 8'h00, 16'h0000, 2'h3, 1'b1, q);
        check(q, {8'h00, ID_VAL});
    endtask : t_regs
    task automatic t_fill;
        for (int c = 0; c < 8; c++) begin
            wr16(mdw_pkg::OFF_WMADDR, {1'b0, c[2:0], 12'h000});
            wr16(mdw_pkg::OFF_WMDATA, val(c, 0));
            wr16(mdw_pkg::OFF_WMDATA, val(c, 1));
        end
        wr16(mdw_pkg::OFF_WMADDR, 16'h3000);
        rd_chk(mdw_pkg::OFF_WMDATA, val(3, 0));
    endtask : t_fill
    task automatic t_step;
        wr16(mdw_pkg::OFF_CTRL, 16'h0008);
        wr16(mdw_pkg::OFF_START, 16'h0001);
        chk_dac(0);
        wr16(mdw_pkg::OFF_START, 16'h0001);
        chk_dac(1);
        rd_chk(mdw_pkg::OFF_SEQPTR, 16'h0002);
        repeat (2046) wr16(mdw_pkg::OFF_START, 16'h0001);
        rd_chk(mdw_pkg::OFF_STATUS, 16'h0001);
        check({15'h0000, irq}, 16'h0000);
        wr16(mdw_pkg::OFF_MASK, 16'h0001);
        check({15'h0000, irq}, 16'h0001);
        wr16(mdw_pkg::OFF_STATUS, 16'h0001);
        check({15'h0000, irq}, 16'h0000);
        wr16(mdw_pkg::OFF_START, 16'h0001);
        chk_dac(0);
    endtask : t_step
    task automatic t_once;
        int n;
        wr16(mdw_pkg::OFF_TIMER, 16'h0000);
        wr16(mdw_pkg::OFF_CTRL, 16'h0005);
        wait_load(n);
        check(n[15:0], 16'd2000);
        @(posedge clk_i);
        ext_trig_n_i <= 1'b0;
        wait_load(n);
        check(n[15:0], 16'd2);
        chk_dac(0);
        wait_load(n);
        check(n[15:0], 16'd268);
        chk_dac(1);
        @(posedge clk_i);
        ext_trig_n_i <= 1'b1;
        wr16(mdw_pkg::OFF_START, 16'h0002);
        rd_chk(mdw_pkg::OFF_STATUS, 16'h0000);
    endtask : t_once
    task automatic t_cont;
        int n;
        // Longest interval clamps to the shortened sim maximum
        wr16(mdw_pkg::OFF_PRESCALE, 16'hFFFF);
        wr16(mdw_pkg::OFF_TIMER, 16'hFFFF);
        wr16(mdw_pkg::OFF_CTRL, 16'h0002);
        wr16(mdw_pkg::OFF_START, 16'h0001);
        chk_dac(0);
        wait_load(n);
        check(n[15:0], 16'd1000);
        chk_dac(1);
        rd_chk(mdw_pkg::OFF_STATUS, 16'h0002);
        wr16(mdw_pkg::OFF_START, 16'h0002);
        wait_load(n);
        check(n[15:0], 16'd2000);
        // Mode 3 must ignore a software trigger
        wr16(mdw_pkg::OFF_CTRL, 16'h0003);
        wr16(mdw_pkg::OFF_START, 16'h0001);
        wait_load(n);
        check(n[15:0], 16'd2000);
    endtask : t_cont
    task automatic final_report;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (40000) @(posedge clk_i);
        err_total++;
        final_report();
    end
    initial begin
        err_total = 0;
        cmp_count = 0;
        resetn_i = 1'b0;
        ext_trig_n_i = 1'b1;
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_regs();
        t_fill();
        t_step();
        t_once();
        t_cont();
        final_report();
    end
endmodule : mdw_sequencer_tb
